// ---- cap_limit_pkg.sv ----
// Constants, register map and state types of the capacity-limit security block.
// Assumes an AHB-Lite master with 32-bit single word transfers.
package cap_limit_pkg;
   localparam logic [7:0] OP_CAP_LIMIT = 8'hF9;
   localparam logic [7:0] OP_READ_NATIVE = 8'hF8;
   localparam logic [7:0] FEAT_SET_PW = 8'h01;
   localparam logic [7:0] FEAT_LOCK = 8'h02;
   localparam logic [7:0] FEAT_UNLOCK = 8'h03;
   localparam logic [7:0] FEAT_FREEZE = 8'h04;
   localparam logic [2:0] TRIES_RESET = 3'h5;
   localparam int PW_WORDS = 16;
   localparam logic [7:0] PW_FIRST = 8'h01;
   localparam logic [7:0] PW_LAST = 8'h10;
   localparam logic [7:0] SECTOR_LAST = 8'hFF;
   // Register byte offsets.
   localparam logic [7:0] A_FEATURE = 8'h00;
   localparam logic [7:0] A_DEVHEAD = 8'h04;
   localparam logic [7:0] A_COMMAND = 8'h08;
   localparam logic [7:0] A_DATA = 8'h0C;
   localparam logic [7:0] A_ERROR = 8'h10;
   localparam logic [7:0] A_STATUS = 8'h14;
   localparam logic [7:0] A_MAXADDR = 8'h18;
   localparam logic [7:0] A_STATE = 8'h1C;
   localparam logic [7:0] A_INT_STAT = 8'h20;
   localparam logic [7:0] A_INT_CLR = 8'h24;
   localparam logic [7:0] A_INT_EN = 8'h28;
   localparam logic [7:0] A_NATIVE = 8'h2C;
   // Bit positions.
   localparam int ABORT_BIT = 2;
   localparam int BUSY_BIT = 7;
   localparam int READY_BIT = 6;
   localparam int REQ_BIT = 3;
   localparam int ERR_BIT = 0;
   localparam int LBA_BIT = 6;
   localparam int EV_DONE = 0;
   localparam int EV_ABORT = 1;
   localparam int EV_DRQ = 2;
   localparam logic [27:0] NATIVE_MAX_RESET = 28'hFFFFFFF;
   localparam logic [3:0] MAX_HEAD = 4'hF;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   typedef enum logic [1:0] {UNLOCKED = 2'b00, LOCKED = 2'b01, FROZEN = 2'b11} lock_t;
   typedef enum logic [1:0] {IDLE = 2'b00, XFER = 2'b01, CHECK = 2'b11} cmd_t;
   typedef enum logic [1:0] {K_NONE = 2'b00, K_SETPW = 2'b01, K_UNLOCK = 2'b11} kind_t;
endpackage

// ---- pw_store.sv ----
`timescale 1ns/100ps
// Password memory: sixteen 16-bit words with registered read data.
// Assumes one write or one read per cycle from the command sequencer.
module pw_store
(
   input wire logic clk,
   input wire logic we,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   output logic [15:0] rdata
);
   logic [15:0] mem [16];
   // No reset: the contents live until power is removed.
   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule // pw_store

// ---- attempt_ctr.sv ----
`timescale 1ns/100ps
// Unlock attempt counter, loaded on reset and stepped down per mismatch.
// Assumes dec arrives from the same clock domain.
module attempt_ctr
   import cap_limit_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic dec,
   output logic [2:0] count,
   output logic spent
);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count <= TRIES_RESET;
      end
      else if (dec && count != 3'h0)
      begin
         count <= count - 3'h1;
      end
   end
   assign spent = (count == 3'h0);
endmodule // attempt_ctr

// ---- cap_limit_security.sv ----
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
// Capacity-limit security command interpreter with an AHB-Lite register file.
// Assumes one clock, the host writes feature and device/head before the command.
//
// What this block does
// - In LBA mode report max address bits 24-27 in head nibble, else max head.
// - Set-password or unlock right after read-native acts as plain set-max.
// - Lock right after read-native acts as read-native.
// - Password sector: word 0 reserved, words 1-16 password, 17-255 reserved.
// - Password kept until power cycle; accepting set-password leaves block unlocked.
// - Lock enters locked state; only unlock, freeze and read-native then accepted.
// - Stay locked until power cycle, accepted unlock or freeze.
// - Unlock sends one password sector compared against stored password.
// - Mismatch aborts and decrements attempt counter starting at five.
// - At zero attempts every unlock rejected until reset.
// - Match enters unlocked state; all commands accepted, unlock only while attempts remain.
// - Freeze right after read-native acts as plain set-max.
// - After freeze enter frozen state; reject all later commands but read-native.
// - Frozen disables set-max, set-password, lock and unlock.
// - Feature 01h password, 02h lock, 03h unlock, 04h freeze.
// - Without preceding read-native, decode as subcommand by feature value.
module cap_limit_security
   import cap_limit_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output logic IRQ
);
   import cap_limit_pkg::*;

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   // One shared register decode keeps the write strobes and the read mux on the same map.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction
   logic ph_wr;
   logic ph_rd;
   logic [7:0] ph_addr;
   wire take = HSEL && HREADY && HTRANS[1];
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         ph_wr <= 1'b0;
         ph_rd <= 1'b0;
         ph_addr <= 8'h00;
      end
      else
      begin
         ph_wr <= take && HWRITE;
         ph_rd <= take && !HWRITE;
         // The address is held past its phase so the read mux stays valid through the wait state.
         ph_addr <= take ? HADDR[7:0] : ph_addr;
      end
   end
   // Write strobes fire in the data phase, the only cycle in which HWDATA stands.
   wire w_feat = ph_wr && hit(ph_addr, A_FEATURE);
   wire w_dh = ph_wr && hit(ph_addr, A_DEVHEAD);
   wire w_cmd = ph_wr && hit(ph_addr, A_COMMAND);
   wire w_data = ph_wr && hit(ph_addr, A_DATA);
   wire w_clr = ph_wr && hit(ph_addr, A_INT_CLR);
   wire w_en = ph_wr && hit(ph_addr, A_INT_EN);
   wire w_max = ph_wr && hit(ph_addr, A_MAXADDR);
   wire w_native = ph_wr && hit(ph_addr, A_NATIVE);
   // Read-ahead decode of the data register on the address phase; left unused, HRDATA is loaded from the ph_addr decode instead.
   wire r_data_ahead = take && !HWRITE && HADDR[7:0] == A_DATA;

   // ****************************************************************
   // Command-block registers
   // ****************************************************************
   logic [7:0] feature;
   logic [7:0] dev_head;
   logic [27:0] max_addr;
   logic [27:0] native_max;
   logic after_native;
   lock_t lock_state;
   cmd_t cmd_state;
   kind_t kind;
   logic [7:0] word_idx;
   logic busy;
   logic drq;
   logic abort;
   logic mismatch;
   logic [2:0] int_stat;
   logic [2:0] int_en;

   wire [7:0] command = HWDATA[7:0];
   wire is_cap = command == OP_CAP_LIMIT;
   wire is_native = command == OP_READ_NATIVE;
   // Commands written while busy are dropped, so the host must see busy low first.
   wire go = w_cmd && !busy;
   wire [2:0] tries;
   wire tries_spent;

   // Feature decode with the read-native override applied.
   wire f_pw = feature == FEAT_SET_PW;
   wire f_lock = feature == FEAT_LOCK;
   wire f_unl = feature == FEAT_UNLOCK;
   wire f_frz = feature == FEAT_FREEZE;
   wire as_setmax = after_native && (f_pw || f_unl || f_frz);
   wire as_native = after_native && f_lock;
   wire sub = !after_native;
   wire rej_setmax = lock_state != UNLOCKED;
   wire rej_pw = sub && f_pw && lock_state != UNLOCKED;
   wire rej_lock = sub && f_lock && lock_state != UNLOCKED;
   wire rej_unl = sub && f_unl && (lock_state == FROZEN || tries_spent);
   wire rej_frz = sub && f_frz && lock_state == FROZEN;
   // Without a preceding read-native, unknown features abort rather than fall through, so a bad value never changes state.
   wire rej_bad = sub && !(f_pw || f_lock || f_unl || f_frz);
   wire cap_reject = (as_setmax && rej_setmax) || rej_pw || rej_lock || rej_unl || rej_frz || rej_bad;

   // ****************************************************************
   // Password transfer and compare
   // ****************************************************************
   wire in_pw = word_idx >= PW_FIRST && word_idx <= PW_LAST;
   wire [3:0] pw_addr = 4'(word_idx - PW_FIRST);
   wire pw_we = w_data && drq && kind == K_SETPW && in_pw;
   wire [15:0] pw_rd;
   logic cmp_pend;
   logic [15:0] cmp_word;
   // The compare trails each data write by one cycle and is pipelined, so data words may arrive back to back.
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         cmp_pend <= 1'b0;
         cmp_word <= 16'h0000;
      end
      else
      begin
         cmp_pend <= w_data && drq && kind == K_UNLOCK && in_pw;
         cmp_word <= HWDATA[15:0];
      end
   end

   pw_store u_pw
   (
      .clk(REF_CLK),
      .we(pw_we),
      .addr(pw_addr),
      .wdata(HWDATA[15:0]),
      .rdata(pw_rd)
   );

   // The counter sits on the hard reset, so only a reset gives the attempts back.
   wire fail_dec = cmd_state == CHECK && kind == K_UNLOCK && mismatch;
   attempt_ctr u_ctr
   (
      .clk(REF_CLK),
      .rst_n(RSTN),
      .dec(fail_dec),
      .count(tries),
      .spent(tries_spent)
   );

   // ****************************************************************
   // Command sequencer
   // ****************************************************************
   wire last_word = word_idx == SECTOR_LAST;
   wire done_ev = (go && is_cap && (cap_reject || !(sub && (f_pw || f_unl)))) || (go && is_native)
      || cmd_state == CHECK;
   wire abort_ev = (go && is_cap && cap_reject) || fail_dec;
   // The start of a sector transfer is an event of its own, so software may feed data on interrupt.
   wire drq_ev = go && is_cap && sub && (f_pw || f_unl) && !cap_reject;
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         cmd_state <= IDLE;
         kind <= K_NONE;
         word_idx <= 8'h00;
         busy <= 1'b0;
         drq <= 1'b0;
         abort <= 1'b0;
         mismatch <= 1'b0;
         lock_state <= UNLOCKED;
         after_native <= 1'b0;
         max_addr <= NATIVE_MAX_RESET;
      end
      else
      begin
         if (cmp_pend && cmp_word != pw_rd)
         begin
            mismatch <= 1'b1;
         end
         case (cmd_state)
            IDLE:
            begin
               if (go)
               begin
                  // Commands other than read-native, or a lock acting as read-native, clear the follow-on flag, so it covers the next command.
                  after_native <= is_native || (is_cap && as_native);
                  abort <= 1'b0;
                  mismatch <= 1'b0;
                  if (is_cap && cap_reject)
                  begin
                     abort <= 1'b1;
                  end
                  else if (is_cap && as_setmax)
                  begin
                     max_addr <= {dev_head[3:0], max_addr[23:0]};
                  end
                  else if (is_cap && sub && f_lock)
                  begin
                     lock_state <= LOCKED;
                  end
                  else if (is_cap && sub && f_frz)
                  begin
                     lock_state <= FROZEN;
                  end
                  else if (is_cap && sub && (f_pw || f_unl))
                  begin
                     kind <= f_pw ? K_SETPW : K_UNLOCK;
                     word_idx <= 8'h00;
                     busy <= 1'b1;
                     drq <= 1'b1;
                     cmd_state <= XFER;
                  end
               end
            end
            XFER:
            begin
               if (w_data)
               begin
                  word_idx <= word_idx + 8'h01;
                  if (last_word)
                  begin
                     drq <= 1'b0;
                     cmd_state <= CHECK;
                  end
               end
            end
            // The mismatch flag is final only here, after the last compare has drained.
            CHECK:
            begin
               busy <= 1'b0;
               kind <= K_NONE;
               cmd_state <= IDLE;
               if (kind == K_UNLOCK && mismatch)
               begin
                  abort <= 1'b1;
               end
               else if (kind == K_UNLOCK)
               begin
                  lock_state <= UNLOCKED;
               end
            end
            default:
            begin
               cmd_state <= IDLE;
            end
         endcase
         // Direct writes obey the same lock as the set-max command, or the lock could be bypassed.
         if (w_max && cmd_state == IDLE && !rej_setmax)
         begin
            max_addr <= HWDATA[27:0];
         end
      end
   end

   // ****************************************************************
   // Host-facing registers and interrupt
   // ****************************************************************
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         feature <= 8'h00;
         dev_head <= 8'h00;
         native_max <= NATIVE_MAX_RESET;
         int_stat <= 3'h0;
         int_en <= 3'h0;
      end
      else
      begin
         feature <= w_feat ? HWDATA[7:0] : feature;
         dev_head <= w_dh ? HWDATA[7:0] : dev_head;
         native_max <= w_native ? HWDATA[27:0] : native_max;
         int_en <= w_en ? HWDATA[2:0] : int_en;
         // Set wins over clear so an event in the clearing cycle survives.
         int_stat <= (int_stat & ~(w_clr ? HWDATA[2:0] : 3'h0)) | {drq_ev, abort_ev, done_ev};
      end
   end

   wire [7:0] error_flags = {5'h00, abort, 2'h0};
   // Ready is the inverse of busy: this block never reports a device fault.
   wire err_flag = abort && !busy;
   wire [7:0] status_flags = {busy, !busy, 2'h0, drq, 2'h0, err_flag};
   wire [3:0] head_nib = dev_head[LBA_BIT] ? max_addr[27:24] : MAX_HEAD;
   wire [31:0] rd_mux =
      hit(ph_addr, A_FEATURE) ? {24'h0, feature} :
      hit(ph_addr, A_DEVHEAD) ? {24'h0, dev_head[7:4], head_nib} :
      hit(ph_addr, A_ERROR) ? {24'h0, error_flags} :
      hit(ph_addr, A_STATUS) ? {24'h0, status_flags} :
      hit(ph_addr, A_MAXADDR) ? {4'h0, max_addr} :
      hit(ph_addr, A_NATIVE) ? {4'h0, native_max} :
      hit(ph_addr, A_STATE) ? {24'h0, tries, 1'b0, kind, lock_state} :
      hit(ph_addr, A_INT_STAT) ? {29'h0, int_stat} :
      hit(ph_addr, A_INT_EN) ? {29'h0, int_en} : 32'h0;

   // Read data is flopped one extra cycle, so reads take a wait state.
   logic rd_wait;
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         HRDATA <= 32'h0;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         IRQ <= 1'b0;
         rd_wait <= 1'b0;
      end
      else
      begin
         rd_wait <= take && !HWRITE;
         HREADYOUT <= !(take && !HWRITE);
         HRDATA <= ph_rd ? rd_mux : HRDATA;
         HRESP <= 1'b0;
         // The interrupt is flopped so it cannot glitch while several status bits change.
         IRQ <= |(int_stat & int_en);
      end
   end
   wire unused_ok = &{1'b0, HSIZE, r_data_ahead, rd_wait, PW_WORDS[0], HTRANS_NONSEQ[0]};
endmodule // cap_limit_security

// ---- cap_limit_security_sva.sv ----
// Checker of the capacity-limit security block, watching its top ports only.
// Assumes one AHB-Lite slave, so HREADY is the block's own HREADYOUT.
`timescale 1ns/100ps
module cap_limit_checker
   import cap_limit_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic IRQ
);
   logic dph_rd;
   logic [7:0] dph_a;
   logic frz_seen;
   logic [2:0] last_tries;
   wire take_rd = HSEL & HREADY & HTRANS[1] & !HWRITE;
   wire rd_end = dph_rd & HREADYOUT;
   wire st_rd = rd_end & (dph_a == A_STATE);
   // ***
   // Read tracking
   // ***
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         dph_rd <= 1'b0;
         dph_a <= 8'h00;
         frz_seen <= 1'b0;
         last_tries <= TRIES_RESET;
      end
      else
      begin
         if (HREADY)
         begin
            dph_rd <= take_rd;
            dph_a <= HADDR[7:0];
         end
         if (st_rd)
         begin
            frz_seen <= frz_seen | (HRDATA[1:0] == FROZEN);
            last_tries <= HRDATA[7:5];
         end
      end
   end
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RSTN);
   sequence s_take; take_rd; endsequence
   sequence s_wait; !HREADYOUT ##1 HREADYOUT; endsequence
   property p_rd_wait; s_take |=> s_wait; endproperty
   property p_okay; !HRESP; endproperty
   property p_rd_hold; !dph_rd ##1 !dph_rd |-> $stable(HRDATA); endproperty
   property p_lock_enc; st_rd |-> HRDATA[1:0] != 2'h2; endproperty
   property p_tries; st_rd |-> HRDATA[7:5] <= last_tries; endproperty
   property p_frozen; st_rd && frz_seen |-> HRDATA[1:0] == FROZEN; endproperty
   property p_head; rd_end && dph_a == A_DEVHEAD && !HRDATA[LBA_BIT] |-> HRDATA[3:0] == MAX_HEAD; endproperty
   property p_err; rd_end && dph_a == A_STATUS && HRDATA[ERR_BIT] |-> !HRDATA[BUSY_BIT]; endproperty
   property p_drq; rd_end && dph_a == A_STATUS && HRDATA[REQ_BIT] |-> HRDATA[BUSY_BIT] && !HRDATA[READY_BIT]; endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   a_okay: assert property (p_okay) else $error("response not okay");
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   a_lock_enc: assert property (p_lock_enc) else $error("bad lock code");
   a_tries: assert property (p_tries) else $error("attempts rose");
   a_frozen: assert property (p_frozen) else $error("left frozen");
   a_head: assert property (p_head) else $error("head nibble wrong");
   a_err: assert property (p_err) else $error("error while busy");
   a_drq: assert property (p_drq) else $error("data request while idle");
endmodule // cap_limit_checker
bind cap_limit_security cap_limit_checker u_chk (.REF_CLK(REF_CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR),
   .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ));

// ---- ahb_host.sv ----
// Behavioural AHB-Lite master standing in for the host controller.
// Assumes its tasks are entered just after a rising clock edge.
`timescale 1ns/100ps
module ahb_host
   import cap_limit_pkg::*;
(
   input wire logic clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   output logic timed_out
);
   logic [31:0] rdat;
   event got_ev;
   initial
   begin
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      timed_out = 1'b0;
   end
   task automatic wait_rdy();
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (!hready && n < 200);
      if (!hready)
         timed_out = 1'b1;
   endtask
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      if (!wr)
      begin
         rdat = hrdata;
         -> got_ev;
      end
   endtask
endmodule // ahb_host

// ---- cap_limit_security_tb.sv ----
// Self-checking bench of the capacity-limit security block.
// Assumes the host model is the only master on the register bus.
`timescale 1ns/100ps
module cap_limit_security_tb;
   import cap_limit_pkg::*;
   logic clk, rstn, hsel, hwrite, hrdy, hresp, irq, timed_out;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [63:0] expq[$];
   logic [63:0] v;
   logic [15:0] seed;
   logic [15:0] pw[16];
   int fails;
   int tests_run;
   cap_limit_security dut (.REF_CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .IRQ(irq));
   ahb_host u_host (.clk(clk), .hready(hrdy), .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .timed_out(timed_out));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      expq.push_back({m, e & m});
      u_host.xfer(1'b0, a, 32'h0);
   endtask
   task automatic cmd(input logic [7:0] f);
      wr(A_FEATURE, {24'h0, f});
      wr(A_COMMAND, {24'h0, OP_CAP_LIMIT});
      idle(3);
   endtask
   task automatic sector(input logic [7:0] f, input logic [15:0] flip);
      cmd(f);
      rd(A_STATUS, 32'h88, 32'h89);
      for (int i = 0; i < 256; i++)
      begin
         seed = lfsr(seed);
         wr(A_DATA, {16'h0, (i >= 1 && i <= PW_WORDS) ? pw[i - 1] ^ flip : seed});
         idle(2);
      end
      idle(4);
   endtask
   always @(u_host.got_ev)
   begin
      v = expq.pop_front();
      check(u_host.rdat & v[63:32], v[31:0]);
   end
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      fork
         wait (timed_out === 1'b1);
         repeat (100000) @(posedge clk);
      join_any
      fails++;
      end_of_test();
   end
   initial
   begin
      rstn = 1'b0;
      seed = 16'h001F;
      fails = 0;
      tests_run = 0;
      idle(16);
      rstn <= 1'b1;
      idle(1);
      rd(A_STATE, 32'hA0, 32'hFF);
      rd(8'h30, 32'h0, 32'hFFFFFFFF);
      wr(A_MAXADDR, 32'h03456789);
      wr(A_DEVHEAD, 32'h40);
      rd(A_DEVHEAD, 32'h3, 32'hF);
      wr(A_DEVHEAD, 32'h0);
      rd(A_DEVHEAD, 32'hF, 32'hF);
      foreach (pw[k])
      begin
         seed = lfsr(seed);
         pw[k] = seed;
      end
      wr(A_INT_EN, 32'h3);
      sector(FEAT_SET_PW, 16'h0);
      rd(A_STATUS, 32'h0, 32'h89);
      rd(A_INT_STAT, 32'h5, 32'h7);
      check({31'h0, irq}, 32'h1);
      wr(A_INT_EN, 32'h0);
      idle(3);
      check({31'h0, irq}, 32'h0);
      wr(A_INT_CLR, 32'h7);
      rd(A_INT_STAT, 32'h0, 32'h7);
      cmd(FEAT_LOCK);
      rd(A_STATE, 32'h1, 32'h3);
      cmd(FEAT_LOCK);
      rd(A_ERROR, 32'h4, 32'h4);
      rd(A_STATUS, 32'h1, 32'h81);
      wr(A_MAXADDR, 32'h0);
      rd(A_MAXADDR, 32'h03456789, 32'h0FFFFFFF);
      for (int k = 4; k >= 0; k--)
      begin
         sector(FEAT_UNLOCK, 16'h0100);
         rd(A_ERROR, 32'h4, 32'h4);
         rd(A_STATE, {24'h0, k[2:0], 5'h01}, 32'hE3);
      end
      cmd(FEAT_UNLOCK);
      rd(A_STATE, 32'h01, 32'hE3);
      rstn <= 1'b0;
      idle(2);
      rstn <= 1'b1;
      idle(1);
      cmd(FEAT_LOCK);
      sector(FEAT_UNLOCK, 16'h0);
      rd(A_ERROR, 32'h0, 32'h4);
      rd(A_STATE, 32'hA0, 32'hE3);
      for (int f = 1; f <= 4; f++)
      begin
         wr(A_FEATURE, f);
         wr(A_DEVHEAD, 32'h44 + f);
         wr(A_COMMAND, {24'h0, OP_READ_NATIVE});
         wr(A_COMMAND, {24'h0, OP_CAP_LIMIT});
         idle(3);
         rd(A_STATUS, 32'h0, 32'h88);
         rd(A_DEVHEAD, (f == 2) ? 32'h5 : 32'h4 + f, 32'hF);
         rd(A_STATE, 32'h0, 32'h3);
      end
      cmd(FEAT_FREEZE);
      rd(A_STATE, 32'h3, 32'h3);
      for (int f = 1; f <= 4; f++)
      begin
         cmd(f[7:0]);
         rd(A_ERROR, 32'h4, 32'h4);
      end
      rd(A_STATE, 32'h3, 32'h3);
      end_of_test();
   end
endmodule // cap_limit_security_tb
